// ===== hdl/p9pfs_pkg.sv
// constants for the port 9 upper pin function select block
package p9pfs_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int P9PFS_ADDR_W = 12;
    localparam int P9PFS_IDX_W = 10;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_TIMER_B3_MODE = 10'h35B;
    localparam logic [9:0] IDX_TIMER_B4_MODE = 10'h35C;
    localparam logic [9:0] IDX_SERIAL4_CONTROL = 10'h366;
    localparam logic [9:0] IDX_ANALOG_CONVERT_CONTROL_1 = 10'h3D7;
    localparam logic [9:0] IDX_DAC_CONTROL = 10'h3DC;
    localparam logic [9:0] IDX_PORT9_PIN_LEVEL = 10'h3F0;
    localparam logic [9:0] IDX_PORT9_OUTPUT_DATA = 10'h3F1;
    localparam logic [9:0] IDX_PORT9_DIRECTION = 10'h3F3;
    localparam logic [9:0] IDX_PULLUP_CONTROL_GROUP = 10'h3FE;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_LINE5 = 5;
    localparam int BIT_LINE4 = 4;
    localparam int BIT_LINE3 = 3;
    localparam int BIT_PULLUP_P94_P97 = 3;
    localparam int BIT_PULLUP_P90_P93 = 2;
    localparam int BIT_OPAMP_MODE_HI = 7;
    localparam int BIT_OPAMP_MODE_LO = 6;
    localparam int BIT_SERIAL4_PORT_SEL = 3;
    localparam int BIT_SERIAL4_CLK_OUT = 6;
    localparam int BIT_DAC1_EN = 1;
    localparam int BIT_DAC0_EN = 0;
    localparam int BIT_TIMER_EVENT_SEL = 7;

    // ------------------------------------------------------------
    // op-amp mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] OPAMP_OFF = 2'h0;
    localparam logic [1:0] OPAMP_ANEX_IN = 2'h1;
    localparam logic [1:0] OPAMP_CONNECT = 2'h3;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // synchroniser depth
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;

endpackage

// ===== hdl/p9pfs_sync.sv
// two-stage synchroniser for the asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none

module p9pfs_sync #(
    parameter int WIDTH = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import p9pfs_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } p9pfs_sync_state_t;

    p9pfs_sync_state_t st_reg;
    p9pfs_sync_state_t st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next = st_reg;
        st_next.meta = async_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stable;

endmodule

`default_nettype wire

// ===== hdl/p9pfs_top.sv
// port 9 lines 5..3 pin function select with apb register access
//
// Operation
// - line5 is gp output when direction 1 and op-amp, serial select 0.
// - one pull-up bit covers lines 4 through 7 together.
// - line5 routes to analog extension input when op-amp mode is 01.
// - line5 becomes op-amp connection output when op-amp mode is 11.
// - serial select gives line5 to serial clock; clock-out bit sets oe.
// - direction 0, pull-up 0, no function: plain input without pull-up.
// - pull-up applies only with direction 0 and group bit 1.
// - dac enables drive line4 with channel 1, line3 with channel 0.
// - timer b4/b3 count from lines 4/3 when event bit 0, input, no dac.
// - direction bits 4 and 3 make lines 4 and 3 outputs when 1 and their dac channel is off.
// - line3 pull-up comes from the bit shared with lines 0 to 2.
`timescale 1ns/1ns
`default_nettype none

module p9pfs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [p9pfs_pkg::P9PFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port9_line5_in,
    output logic port9_line5_out,
    output logic port9_line5_oe,
    output logic port9_line5_pullup,
    input wire logic port9_line4_in,
    output logic port9_line4_out,
    output logic port9_line4_oe,
    output logic port9_line4_pullup,
    input wire logic port9_line3_in,
    output logic port9_line3_out,
    output logic port9_line3_oe,
    output logic port9_line3_pullup,
    input wire logic serial_unit4_clock_out,
    output logic serial_unit4_clock_in,
    output logic analog_extension_input_0_en,
    output logic analog_extension_input_0_drive_en,
    output logic dac_channel_one_output_en,
    output logic dac_channel_zero_output_en,
    output logic timer_b4_count_input,
    output logic timer_b3_count_input
);
    import p9pfs_pkg::*;

    typedef struct packed {
        logic [7:0] serial4_control;
        logic [7:0] timer_b3_mode;
        logic [7:0] timer_b4_mode;
        logic [7:0] analog_convert_control_1;
        logic [7:0] dac_control;
        logic [7:0] port9_direction;
        logic [7:0] pullup_control_group;
        logic [7:0] port9_output_data;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic [2:0] pin_out;
        logic [2:0] pin_oe;
        logic [2:0] pin_pu;
        logic sclk_in;
        logic anex_en;
        logic anex_drive;
        logic dac1_en;
        logic dac0_en;
        logic tb4_in;
        logic tb3_in;
    } p9pfs_state_t;

    p9pfs_state_t st_reg;
    p9pfs_state_t st_next;
    logic [2:0] pin_sync;
    logic [2:0] pin_async;

    // ------------------------------------------------------------
    // pin synchronisers (bit 2 = line5, 1 = line4, 0 = line3)
    // ------------------------------------------------------------
    assign pin_async = {port9_line5_in, port9_line4_in, port9_line3_in};

    p9pfs_sync #(
        .WIDTH(3)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_async),
        .sync_out(pin_sync)
    );

    // ------------------------------------------------------------
    // next state: apb slave and pin decode
    // ------------------------------------------------------------
    always_comb begin
        logic done;
        logic wr;
        logic hit;
        logic [7:0] rd8;
        logic [9:0] idx;
        logic [1:0] opm;
        logic sel4;
        logic p5_func;
        logic p4_func;
        logic p3_func;
        st_next = st_reg;
        opm = st_reg.analog_convert_control_1[BIT_OPAMP_MODE_HI:
                                              BIT_OPAMP_MODE_LO];
        sel4 = st_reg.serial4_control[BIT_SERIAL4_PORT_SEL];
        p5_func = 1'b0;
        p4_func = st_reg.dac_control[BIT_DAC1_EN];
        p3_func = st_reg.dac_control[BIT_DAC0_EN];
        idx = paddr[P9PFS_ADDR_W-1:2];
        // one wait state: pready rises in the second access cycle
        done = psel && penable && st_reg.ready;
        wr = done && pwrite && pstrb[0];
        hit = 1'b1;
        rd8 = 8'h00;
        unique case (idx)
            IDX_SERIAL4_CONTROL: rd8 = st_reg.serial4_control;
            IDX_TIMER_B3_MODE: rd8 = st_reg.timer_b3_mode;
            IDX_TIMER_B4_MODE: rd8 = st_reg.timer_b4_mode;
            IDX_ANALOG_CONVERT_CONTROL_1: rd8 = st_reg.analog_convert_control_1;
            IDX_DAC_CONTROL: rd8 = st_reg.dac_control;
            IDX_PORT9_DIRECTION: rd8 = st_reg.port9_direction;
            IDX_PULLUP_CONTROL_GROUP: rd8 = st_reg.pullup_control_group;
            IDX_PORT9_OUTPUT_DATA: rd8 = st_reg.port9_output_data;
            IDX_PORT9_PIN_LEVEL: rd8 = {2'h0, pin_sync, 3'h0};
            default: hit = 1'b0;
        endcase
        st_next.ready = psel && penable && !st_reg.ready;
        st_next.slverr = psel && penable && !st_reg.ready && !hit;
        if (psel && penable && !st_reg.ready) begin
            st_next.rdata = (hit && !pwrite) ? {24'h0, rd8} : RST_RDATA;
        end
        if (wr) begin
            unique case (idx)
                IDX_SERIAL4_CONTROL: st_next.serial4_control = pwdata[7:0];
                IDX_TIMER_B3_MODE: st_next.timer_b3_mode = pwdata[7:0];
                IDX_TIMER_B4_MODE: st_next.timer_b4_mode = pwdata[7:0];
                IDX_ANALOG_CONVERT_CONTROL_1: begin
                    st_next.analog_convert_control_1 = pwdata[7:0];
                end
                IDX_DAC_CONTROL: st_next.dac_control = pwdata[7:0];
                IDX_PORT9_DIRECTION: st_next.port9_direction = pwdata[7:0];
                IDX_PULLUP_CONTROL_GROUP: begin
                    st_next.pullup_control_group = pwdata[7:0];
                end
                IDX_PORT9_OUTPUT_DATA: st_next.port9_output_data = pwdata[7:0];
                default: ;
            endcase
        end

        // -------- line5: serial clock, analog extension, gp --------
        st_next.sclk_in = 1'b0;
        st_next.anex_en = 1'b0;
        st_next.anex_drive = 1'b0;
        st_next.pin_out[2] = st_reg.port9_output_data[BIT_LINE5];
        st_next.pin_oe[2] = 1'b0;
        // serial select wins over the op-amp mode bits
        if (sel4) begin
            p5_func = 1'b1;
            st_next.pin_out[2] = serial_unit4_clock_out;
            st_next.pin_oe[2] =
                st_reg.serial4_control[BIT_SERIAL4_CLK_OUT];
            st_next.sclk_in =
                !st_reg.serial4_control[BIT_SERIAL4_CLK_OUT]
                && pin_sync[2];
        end else if (opm == OPAMP_ANEX_IN) begin
            p5_func = 1'b1;
            st_next.anex_en = 1'b1;
        end else if (opm == OPAMP_CONNECT) begin
            p5_func = 1'b1;
            // analog drive; the digital driver stays off
            st_next.anex_en = 1'b1;
            st_next.anex_drive = 1'b1;
        end else begin
            // mode 10 is not a listed setting and falls to gp use
            st_next.pin_oe[2] =
                st_reg.port9_direction[BIT_LINE5];
        end
        st_next.pin_pu[2] = !p5_func && !st_reg.port9_direction[BIT_LINE5]
            && st_reg.pullup_control_group[BIT_PULLUP_P94_P97];

        // -------- line4: dac channel 1, timer b4, gp --------
        st_next.dac1_en = p4_func;
        st_next.pin_out[1] = st_reg.port9_output_data[BIT_LINE4];
        st_next.pin_oe[1] = !p4_func
            && st_reg.port9_direction[BIT_LINE4];
        st_next.pin_pu[1] = !p4_func && !st_reg.port9_direction[BIT_LINE4]
            && st_reg.pullup_control_group[BIT_PULLUP_P94_P97];
        st_next.tb4_in = !st_reg.timer_b4_mode[BIT_TIMER_EVENT_SEL]
            && !st_reg.port9_direction[BIT_LINE4] && !p4_func
            && pin_sync[1];

        // -------- line3: dac channel 0, timer b3, gp --------
        st_next.dac0_en = p3_func;
        st_next.pin_out[0] = st_reg.port9_output_data[BIT_LINE3];
        st_next.pin_oe[0] = !p3_func
            && st_reg.port9_direction[BIT_LINE3];
        st_next.pin_pu[0] = !p3_func && !st_reg.port9_direction[BIT_LINE3]
            && st_reg.pullup_control_group[BIT_PULLUP_P90_P93];
        st_next.tb3_in = !st_reg.timer_b3_mode[BIT_TIMER_EVENT_SEL]
            && !st_reg.port9_direction[BIT_LINE3] && !p3_func
            && pin_sync[0];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.serial4_control <= RST_REG8;
            st_reg.timer_b3_mode <= RST_REG8;
            st_reg.timer_b4_mode <= RST_REG8;
            st_reg.analog_convert_control_1 <= RST_REG8;
            st_reg.dac_control <= RST_REG8;
            st_reg.port9_direction <= RST_REG8;
            st_reg.pullup_control_group <= RST_REG8;
            st_reg.port9_output_data <= RST_REG8;
            st_reg.rdata <= RST_RDATA;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    assign prdata = st_reg.rdata;
    assign pready = st_reg.ready;
    assign pslverr = st_reg.slverr;
    assign port9_line5_out = st_reg.pin_out[2];
    assign port9_line5_oe = st_reg.pin_oe[2];
    assign port9_line5_pullup = st_reg.pin_pu[2];
    assign port9_line4_out = st_reg.pin_out[1];
    assign port9_line4_oe = st_reg.pin_oe[1];
    assign port9_line4_pullup = st_reg.pin_pu[1];
    assign port9_line3_out = st_reg.pin_out[0];
    assign port9_line3_oe = st_reg.pin_oe[0];
    assign port9_line3_pullup = st_reg.pin_pu[0];
    assign serial_unit4_clock_in = st_reg.sclk_in;
    assign analog_extension_input_0_en = st_reg.anex_en;
    assign analog_extension_input_0_drive_en = st_reg.anex_drive;
    assign dac_channel_one_output_en = st_reg.dac1_en;
    assign dac_channel_zero_output_en = st_reg.dac0_en;
    assign timer_b4_count_input = st_reg.tb4_in;
    assign timer_b3_count_input = st_reg.tb3_in;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_line5_gp_out: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_reg.port9_direction[5] && !st_reg.serial4_control[3]
         && st_reg.analog_convert_control_1[7:6] == 2'h0)
        |=> (port9_line5_oe && !port9_line5_pullup
             && port9_line5_out == $past(st_reg.port9_output_data[5])))
        else $error("line5 not driven as gp output");

    chk_shared_pullup_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_reg.port9_direction[5:4] == 2'h0 && st_reg.dac_control[1] == 1'b0
         && !st_reg.serial4_control[3]
         && st_reg.analog_convert_control_1[7:6] == 2'h0)
        |=> (port9_line5_pullup == port9_line4_pullup))
        else $error("lines 5 and 4 disagree on shared pull-up");

    chk_anex_input: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.serial4_control[3]
         && st_reg.analog_convert_control_1[7:6] == 2'h1)
        |=> (analog_extension_input_0_en && !analog_extension_input_0_drive_en
             && !port9_line5_oe))
        else $error("analog extension input not routed");

    chk_opamp_output: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(st_reg.analog_convert_control_1[7:6] == 2'h3)
        && !st_reg.serial4_control[3]
        |=> analog_extension_input_0_drive_en ##0 !port9_line5_oe)
        else $error("op-amp connection output not enabled");

    chk_serial_clock_dir: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_reg.serial4_control[3]
        |=> (port9_line5_oe == $past(st_reg.serial4_control[6])
             && !port9_line5_pullup))
        else $error("serial clock direction wrong on line5");

    chk_plain_input: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.port9_direction[3] && !st_reg.pullup_control_group[2]
         && !st_reg.dac_control[0])
        |=> (!port9_line3_oe && !port9_line3_pullup
             && !dac_channel_zero_output_en))
        else $error("line3 not a plain input");

    chk_pullup_needs_input: assert property (
        @(posedge pclk) disable iff (!presetn)
        port9_line5_pullup |-> !$past(st_reg.port9_direction[5])
            && $past(st_reg.pullup_control_group[3]))
        else $error("line5 pull-up without input and group bit");

    chk_dac_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_reg.dac_control[1:0] == 2'h3
        |=> (dac_channel_one_output_en && dac_channel_zero_output_en
             && !port9_line4_oe && !port9_line3_oe))
        else $error("dac channels not driving lines 4 and 3");

    chk_timer_count_src: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.timer_b4_mode[7] && !st_reg.port9_direction[4]
         && !st_reg.dac_control[1])
        |=> timer_b4_count_input == $past(pin_sync[1]))
        else $error("timer b4 count not taken from line4");

    chk_line_direction: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_reg.dac_control[1:0] == 2'h0
        |=> (port9_line4_oe == $past(st_reg.port9_direction[4])
             && port9_line3_oe == $past(st_reg.port9_direction[3])))
        else $error("line4 or line3 direction wrong");

    chk_line3_pullup_grp: assert property (
        @(posedge pclk) disable iff (!presetn)
        port9_line3_pullup |-> $past(st_reg.pullup_control_group[2]))
        else $error("line3 pull-up not from its group bit");

endmodule

`default_nettype wire

// ===== verification/p9pfs_pins.sv
// pin and peripheral model around the port 9 upper lines
`timescale 1ns/1ns
`default_nettype none

module p9pfs_pins (
    input wire logic [2:0] oe,
    input wire logic [2:0] out,
    input wire logic [2:0] ext,
    output logic [2:0] level
);
    // ------------------------------------------------------------
    // wire level
    // ------------------------------------------------------------
    // a weak outside driver always holds the line, so the level never
    // floats; the block overpowers it whenever it enables its driver
    assign level = (oe & out) | (~oe & ext);
endmodule

`default_nettype wire

// ===== verification/p9pfs_top_tb.sv
// self-checking bench for the port 9 upper pin function select block
`timescale 1ns/1ns
`default_nettype none

module p9pfs_top_tb;
    import p9pfs_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] oe, po, pu, lvl, ext;
    logic sck, sin, an, adr, d1, d0, t4, t3;
    logic [9:0] ix [8];
    logic [7:0] rv [8];
    int err_count, compares;

    p9pfs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port9_line5_in(lvl[2]), .port9_line5_out(po[2]),
        .port9_line5_oe(oe[2]), .port9_line5_pullup(pu[2]),
        .port9_line4_in(lvl[1]), .port9_line4_out(po[1]),
        .port9_line4_oe(oe[1]), .port9_line4_pullup(pu[1]),
        .port9_line3_in(lvl[0]), .port9_line3_out(po[0]),
        .port9_line3_oe(oe[0]), .port9_line3_pullup(pu[0]),
        .serial_unit4_clock_out(sck), .serial_unit4_clock_in(sin),
        .analog_extension_input_0_en(an),
        .analog_extension_input_0_drive_en(adr),
        .dac_channel_one_output_en(d1), .dac_channel_zero_output_en(d0),
        .timer_b4_count_input(t4), .timer_b3_count_input(t3));

    p9pfs_pins i_pins (.oe(oe), .out(po), .ext(ext), .level(lvl));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] a,
            input logic [7:0] d, input logic [3:0] st);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'h0};
        pwdata <= {24'h0, d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // lines 4 and 3: {oe, out, pullup, dac enable, timer input}
    function automatic logic [4:0] exp43(input logic dac, input logic dir,
            input logic od, input logic pug, input logic lv);
        return dac ? 5'b00010 : {dir, od, ~dir & pug, 1'b0, ~dir & lv};
    endfunction

    task automatic check_pins;
        logic [5:0] e5, m5;
        logic [4:0] e4, e3;
        logic [2:0] le, lm;
        m5 = 6'h2F;
        e4 = exp43(rv[4][1], rv[0][4], rv[7][4], rv[1][3], ext[1]);
        e3 = exp43(rv[4][0], rv[0][3], rv[7][3], rv[1][2], ext[0]);
        if (rv[3][3]) begin
            e5 = {rv[3][6], sck, 1'b0, ~rv[3][6] & ext[2], 2'b00};
            m5[4] = rv[3][6];
        end else if (rv[2][7:6] == OPAMP_ANEX_IN) begin
            e5 = 6'b000010;
        end else if (rv[2][7:6] == OPAMP_CONNECT) begin
            // digital driver state is not defined while analog drives
            e5 = 6'b000011;
            m5[5] = 1'b0;
        end else begin
            e5 = {rv[0][5], rv[7][5], ~rv[0][5] & rv[1][3], 3'b000};
            m5[4] = rv[0][5];
        end
        le = {e5[5] ? e5[4] : ext[2], e4[4] ? e4[3] : ext[1],
              e3[4] ? e3[3] : ext[0]};
        lm = {m5[5], 2'b11};
        chk("line5", 32'({oe[2], po[2], pu[2], sin, an, adr} & m5),
            32'(e5 & m5));
        chk("line4", 32'({oe[1], po[1], pu[1], d1, t4} & {1'b1, e4[4], 3'h7}),
            32'(e4 & {1'b1, e4[4], 3'h7}));
        chk("line3", 32'({oe[0], po[0], pu[0], d0, t3} & {1'b1, e3[4], 3'h7}),
            32'(e3 & {1'b1, e3[4], 3'h7}));
        apb(1'b0, IDX_PORT9_PIN_LEVEL, 8'h00, 4'hF);
        chk("level", rd & {26'h0, lm, 3'h0},
            {26'h0, le & lm, 3'h0});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, sck} = 5'h00;
        {paddr, pwdata, pstrb, ext} = '0;
        err_count = 0;
        compares = 0;
        ix = '{IDX_PORT9_DIRECTION, IDX_PULLUP_CONTROL_GROUP,
               IDX_ANALOG_CONVERT_CONTROL_1, IDX_SERIAL4_CONTROL,
               IDX_DAC_CONTROL, IDX_TIMER_B3_MODE, IDX_TIMER_B4_MODE,
               IDX_PORT9_OUTPUT_DATA};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'hF2AD6D2A));
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, ix[k], 8'h00, 4'hF);
            chk("reset", rd, RST_RDATA);
        end
        apb(1'b0, 10'h000, 8'h00, 4'hF);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        // low strobe off: the byte must not land
        apb(1'b1, ix[0], 8'hFF, 4'hE);
        apb(1'b0, ix[0], 8'h00, 4'hF);
        chk("strobe", rd, RST_RDATA);
        for (int it = 0; it < 40; it++) begin
            for (int k = 0; k < 8; k++) begin
                rv[k] = (it < 6) ? 8'h00 : 8'($urandom);
            end
            case (it)
                1: rv[3] = 8'h48;
                2: rv[3] = 8'h08;
                3: rv[2] = 8'h40;
                4: rv[2] = 8'hC0;
                5: rv[4] = 8'h03;
                default: ;
            endcase
            // only listed combinations are programmed
            rv[5][7] = 1'b0;
            rv[6][7] = 1'b0;
            if (rv[2][7:6] == 2'h2) rv[2][7:6] = OPAMP_OFF;
            if (rv[3][3]) rv[2][7:6] = OPAMP_OFF;
            if (rv[3][3] || rv[2][7:6] != OPAMP_OFF) begin
                rv[0][5] = 1'b0;
                rv[1][3] = 1'b0;
            end
            if (rv[4][1]) rv[1][3] = 1'b0;
            if (rv[4][1]) rv[0][4] = 1'b0;
            if (rv[4][0]) {rv[0][3], rv[1][2]} = 2'b00;
            @(posedge pclk);
            ext <= 3'($urandom);
            sck <= 1'($urandom);
            for (int k = 0; k < 8; k++) apb(1'b1, ix[k], rv[k], 4'hF);
            for (int k = 0; k < 8; k++) begin
                apb(1'b0, ix[k], 8'h00, 4'hF);
                chk("readback", {er, rd[30:0]},
                    {24'h0, rv[k]});
            end
            @(negedge pclk);
            check_pins();
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire
